// ---- trl_params.svh ----
// constants of the triggered sample logger
`ifndef TRL_PARAMS_SVH
`define TRL_PARAMS_SVH
`define TRL_DEPTH 180
`define TRL_PRE_SPLIT_AFTER 160
`define TRL_POST_SPLIT_AFTER 20
`define TRL_CLK_HZ 125000000
`define TRL_SAMPLE_MIN_S 1
`define TRL_SAMPLE_MIN_CYC (`TRL_CLK_HZ * `TRL_SAMPLE_MIN_S)
`define TRL_ADR_CTRL 8'h00
`define TRL_ADR_INTERVAL 8'h04
`define TRL_ADR_STATUS 8'h08
`define TRL_ADR_POINTER 8'h0c
`define TRL_ADR_VALUE 8'h10
`define TRL_ADR_TIME 8'h14
`define TRL_ADR_MIN 8'h18
`define TRL_ADR_MAX 8'h1c
`define TRL_ADR_ALARM 8'h20
`define TRL_ADR_IRQ_STAT 8'h24
`define TRL_ADR_IRQ_MASK 8'h28
`define TRL_ADR_CMD 8'h2c
`define TRL_CMD_HOLD 0
`define TRL_CMD_RUN 1
`define TRL_CMD_TRIG 2
`define TRL_CMD_LIST 3
`define TRL_IRQ_STORED 0
`define TRL_IRQ_FROZEN 1
`define TRL_IRQ_TRIG 2
`define TRL_IRQ_LISTED 3
`endif

// ---- trl_pkg.sv ----
// types of the triggered sample logger
package trl_pkg;
  typedef enum logic [1:0] {TRL_OFF, TRL_CONT, TRL_TRIG_PRE, TRL_TRIG_POST} trl_mode_t;
  typedef struct packed {
    logic [27:0] value;
    logic [27:0] min;
    logic [27:0] max;
    logic [7:0] alarm;
    logic [16:0] tod;
  } trl_rec_t;
  typedef struct packed {
    logic hold;
    logic run;
    logic trig;
    logic list;
  } trl_cmd_t;
endpackage : trl_pkg

// ---- trl_logger.sv ----
// triggered sample logger with wishbone register access
// How it works
// - memory of 180 records, each with its extra information
// - plain ram, nothing reloaded at power-up
// - record holds seven-digit value, min, max, alarm status, time stamp
// - one record per programmed sample interval, one second upward
// - continuous mode overwrites oldest, keeping newest 180
// - optionally clear min and max trackers after each record
// - choosing any mode but off starts running at once
// - hold from keys, pin or serial; records stay readable
// - after hold newest record is -1, older ones further negative
// - trigger in trigger mode ends logging into hold
// - trigger accepted from key, control pin strobe or serial command
// - record at trigger is 0, later positive, earlier negative
// - pre split keeps 20 before and 160 after trigger
// - post split keeps 160 before and 20 after trigger
// - hold without trigger allowed, run resumes logging
// - listing started by key, pin strobe or serial command
// - host selects single records by pointer
`timescale 1ns/1ps
`default_nettype none
`include "trl_params.svh"
module trl_logger
  import trl_pkg::*;
#(
  parameter int DEPTH = `TRL_DEPTH,
  parameter int PRE_AFTER = `TRL_PRE_SPLIT_AFTER,
  parameter int POST_AFTER = `TRL_POST_SPLIT_AFTER,
  parameter int SAMPLE_MIN_CYC = `TRL_SAMPLE_MIN_CYC
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // measurement source
  input wire logic [27:0] meas_value_i,
  input wire logic [7:0] alarm_i,
  input wire logic [16:0] tod_i,
  // front keys and control pin, one-cycle strobes
  input wire trl_cmd_t key_cmd_i,
  input wire trl_cmd_t pin_cmd_i,
  // listing stream
  output logic list_valid_o,
  output trl_rec_t list_rec_o,
  output logic [8:0] list_num_o,
  input wire logic list_ready_i,
  // status
  output logic log_freeze_o,
  output logic irq_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 255 || PRE_AFTER < 2 || POST_AFTER < 2 || PRE_AFTER >= DEPTH ||
      POST_AFTER >= DEPTH || SAMPLE_MIN_CYC < 1)
  begin : g_bad_params
    $error("trl_logger: unsupported parameters");
  end

  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  trl_mode_t mode_reg;
  logic mm_clear_reg;
  logic [23:0] interval_reg;
  logic [AW-1:0] ptr_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic wr_acc;
  logic rd_acc;
  trl_cmd_t sw_cmd;
  trl_cmd_t cmd;
  logic [3:0] irq_set;

  // writes land on the edge that sees ack high
  assign wr_acc = cyc_i && stb_i && ack_reg && we_i;
  assign rd_acc = cyc_i && stb_i && !ack_reg && !we_i;
  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;

  always_comb
  begin
    sw_cmd = '0;
    if (wr_acc && adr_i == `TRL_ADR_CMD && sel_i[0])
    begin
      sw_cmd.hold = dat_i[`TRL_CMD_HOLD];
      sw_cmd.run = dat_i[`TRL_CMD_RUN];
      sw_cmd.trig = dat_i[`TRL_CMD_TRIG];
      sw_cmd.list = dat_i[`TRL_CMD_LIST];
    end
  end

  // any of three sources
  assign cmd = key_cmd_i | pin_cmd_i | sw_cmd;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= cyc_i && stb_i && !ack_reg;
  end

  logic mode_wr;
  assign mode_wr = wr_acc && adr_i == `TRL_ADR_CTRL && sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= TRL_OFF;
      mm_clear_reg <= 1'b0;
      interval_reg <= 24'h000001;
      ptr_reg <= '0;
      irq_mask_reg <= 4'h0;
    end
    else if (wr_acc)
    begin
      case (adr_i)
        `TRL_ADR_CTRL:
        begin
          if (sel_i[0])
          begin
            mode_reg <= trl_mode_t'(dat_i[1:0]);
            mm_clear_reg <= dat_i[2];
          end
        end
        `TRL_ADR_INTERVAL:
        begin
          if (sel_i[0])
            interval_reg[7:0] <= dat_i[7:0];
          if (sel_i[1])
            interval_reg[15:8] <= dat_i[15:8];
          if (sel_i[2])
            interval_reg[23:16] <= dat_i[23:16];
        end
        `TRL_ADR_POINTER:
        begin
          if (sel_i[0])
            ptr_reg <= dat_i[AW-1:0];
        end
        `TRL_ADR_IRQ_MASK:
        begin
          if (sel_i[0])
            irq_mask_reg <= dat_i[3:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sample timebase
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic [23:0] sec_cnt_reg;
  logic sample_tick;
  logic sec_tick;

  assign sec_tick = tick_cnt_reg == 32'(SAMPLE_MIN_CYC - 1);
  assign sample_tick = sec_tick && sec_cnt_reg >= interval_reg - 24'h000001;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || mode_wr)
    begin
      tick_cnt_reg <= '0;
      sec_cnt_reg <= '0;
    end
    else if (sec_tick)
    begin
      tick_cnt_reg <= '0;
      sec_cnt_reg <= sample_tick ? 24'h000000 : sec_cnt_reg + 24'h000001;
    end
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
  end

  // ---------------------------------------------------------------
  // run / hold / trigger control
  // ---------------------------------------------------------------
  logic freeze_reg;
  logic trig_armed_reg;
  logic trig_seen_reg;
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] trig_idx_reg;
  logic [AW:0] count_reg;
  logic [AW:0] after_left_reg;
  logic store;
  logic trig_mode;
  logic listing_reg;

  assign trig_mode = mode_reg == TRL_TRIG_PRE || mode_reg == TRL_TRIG_POST;
  assign store = sample_tick && !freeze_reg && mode_reg != TRL_OFF;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      freeze_reg <= 1'b1;
      trig_seen_reg <= 1'b0;
      after_left_reg <= '0;
      trig_idx_reg <= '0;
    end
    else if (mode_wr)
    begin
      freeze_reg <= dat_i[1:0] == 2'h0;
      trig_seen_reg <= 1'b0;
    end
    else
    begin
      if (cmd.trig && trig_mode && !freeze_reg && !trig_seen_reg)
      begin
        trig_seen_reg <= 1'b1;
        trig_idx_reg <= wptr_reg;
        // a record stored in the trigger cycle is record 0 and already counts
        after_left_reg <= (AW+1)'(mode_reg == TRL_TRIG_PRE ? PRE_AFTER : POST_AFTER) -
                          (AW+1)'(store);
      end
      else if (store && trig_seen_reg)
      begin
        after_left_reg <= after_left_reg - 1'b1;
        if (after_left_reg == (AW+1)'(1))
          freeze_reg <= 1'b1;
      end
      if (cmd.hold)
        freeze_reg <= 1'b1;
      else if (cmd.run && mode_reg != TRL_OFF)
      begin
        freeze_reg <= 1'b0;
        trig_seen_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // record memory and min/max tracking
  // ---------------------------------------------------------------
  trl_rec_t mem [DEPTH];
  logic [27:0] min_reg;
  logic [27:0] max_reg;
  logic mm_valid_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mm_valid_reg <= 1'b0;
    else if (store && mm_clear_reg)
      mm_valid_reg <= 1'b0;
    else
      mm_valid_reg <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!mm_valid_reg || $signed(meas_value_i) < $signed(min_reg))
      min_reg <= meas_value_i;
    if (!mm_valid_reg || $signed(meas_value_i) > $signed(max_reg))
      max_reg <= meas_value_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (store)
      mem[wptr_reg] <= '{value: meas_value_i, min: min_reg, max: max_reg,
                         alarm: alarm_i, tod: tod_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || mode_wr)
    begin
      wptr_reg <= '0;
      count_reg <= '0;
    end
    else if (store)
    begin
      wptr_reg <= wptr_reg == AW'(DEPTH - 1) ? '0 : wptr_reg + 1'b1;
      if (count_reg != (AW+1)'(DEPTH))
        count_reg <= count_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // record numbering and readout
  // ---------------------------------------------------------------
  // index of a slot counted back from the reference point
  function automatic logic [AW-1:0] slot_of(input logic [AW-1:0] base, input logic [AW:0] back);
    logic [AW+1:0] s;
    s = {2'b00, base} + (AW+2)'(DEPTH) - {1'b0, back};
    if (s >= (AW+2)'(DEPTH))
      s = s - (AW+2)'(DEPTH);
    return s[AW-1:0];
  endfunction : slot_of

  // pointer k selects oldest..newest; number is relative to hold or trigger
  function automatic logic [8:0] num_of(input logic [AW-1:0] k);
    logic [AW-1:0] slot;
    logic [AW+1:0] d;
    logic [AW:0] done;
    slot = slot_of(wptr_reg, count_reg - (AW+1)'(k));
    done = (AW+1)'(mode_reg == TRL_TRIG_PRE ? PRE_AFTER : POST_AFTER) - after_left_reg;
    if (trig_seen_reg)
    begin
      d = {2'b00, slot} + (AW+2)'(DEPTH) - {2'b00, trig_idx_reg};
      if (d >= (AW+2)'(DEPTH))
        d = d - (AW+2)'(DEPTH);
      // slots beyond those written since the trigger lie before it
      if (d >= {1'b0, done})
        d = d - (AW+2)'(DEPTH);
      return 9'(d);
    end
    return 9'(k) - 9'(count_reg);
  endfunction : num_of

  logic [AW-1:0] list_k_reg;
  logic [AW-1:0] rd_slot;
  assign rd_slot = slot_of(wptr_reg, count_reg - (AW+1)'(ptr_reg));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      listing_reg <= 1'b0;
      list_k_reg <= '0;
      list_valid_o <= 1'b0;
      list_rec_o <= '0;
      list_num_o <= '0;
    end
    else if (!listing_reg)
    begin
      if (cmd.list && count_reg != '0)
      begin
        listing_reg <= 1'b1;
        list_k_reg <= '0;
      end
    end
    else if (!list_valid_o || list_ready_i)
    begin
      if (list_valid_o && (AW+1)'(list_k_reg) == count_reg)
      begin
        list_valid_o <= 1'b0;
        listing_reg <= 1'b0;
      end
      else
      begin
        list_valid_o <= 1'b1;
        list_rec_o <= mem[slot_of(wptr_reg, count_reg - (AW+1)'(list_k_reg))];
        list_num_o <= num_of(list_k_reg);
        list_k_reg <= list_k_reg + 1'b1;
      end
    end
  end

  assign log_freeze_o = freeze_reg;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign irq_set[`TRL_IRQ_STORED] = store;
  assign irq_set[`TRL_IRQ_FROZEN] = !freeze_reg && (cmd.hold || (store && trig_seen_reg &&
                                    after_left_reg == (AW+1)'(1)));
  assign irq_set[`TRL_IRQ_TRIG] = cmd.trig && trig_mode && !freeze_reg && !trig_seen_reg;
  assign irq_set[`TRL_IRQ_LISTED] = listing_reg && list_valid_o && list_ready_i &&
                                    (AW+1)'(list_k_reg) == count_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= 4'h0;
    else if (wr_acc && adr_i == `TRL_ADR_IRQ_STAT && sel_i[0])
      irq_stat_reg <= (irq_stat_reg & ~dat_i[3:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  trl_rec_t sel_rec;
  assign sel_rec = mem[rd_slot];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_reg <= '0;
    else if (rd_acc)
    begin
      case (adr_i)
        `TRL_ADR_CTRL: rdat_reg <= {29'h0, mm_clear_reg, mode_reg};
        `TRL_ADR_INTERVAL: rdat_reg <= {8'h00, interval_reg};
        `TRL_ADR_STATUS: rdat_reg <= {13'h0, listing_reg, trig_seen_reg, freeze_reg,
                                      8'(count_reg), 8'(wptr_reg)};
        `TRL_ADR_POINTER: rdat_reg <= {7'h00, num_of(ptr_reg), 8'h00, 8'(ptr_reg)};
        `TRL_ADR_VALUE: rdat_reg <= {4'h0, sel_rec.value};
        `TRL_ADR_TIME: rdat_reg <= {15'h0, sel_rec.tod};
        `TRL_ADR_MIN: rdat_reg <= {4'h0, sel_rec.min};
        `TRL_ADR_MAX: rdat_reg <= {4'h0, sel_rec.max};
        `TRL_ADR_ALARM: rdat_reg <= {24'h0, sel_rec.alarm};
        `TRL_ADR_IRQ_STAT: rdat_reg <= {28'h0, irq_stat_reg};
        `TRL_ADR_IRQ_MASK: rdat_reg <= {28'h0, irq_mask_reg};
        default: rdat_reg <= 32'h00000000;
      endcase
    end
  end
endmodule : trl_logger
`default_nettype wire

// ---- trl_monitor.sv ----
// port checker of the triggered sample logger
`timescale 1ns/1ps
`default_nettype none
module trl_monitor
  import trl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // commands
  input wire trl_cmd_t key_cmd_i,
  input wire trl_cmd_t pin_cmd_i,
  // listing and status
  input wire logic list_valid_o,
  input wire logic list_ready_i,
  input wire trl_rec_t list_rec_o,
  input wire logic [8:0] list_num_o,
  input wire logic log_freeze_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack_o |-> $past(stb_i))
    else $error("ack without request");
  a_hold_freezes: assert property ((key_cmd_i.hold || pin_cmd_i.hold) && !cyc_i |=> log_freeze_o)
    else $error("hold did not freeze");
  a_freeze_stays: assert property (log_freeze_o && !key_cmd_i.run && !pin_cmd_i.run && !cyc_i
    |=> log_freeze_o)
    else $error("freeze left without run");
  a_list_stall: assert property (list_valid_o && !list_ready_i
    |=> list_valid_o && $stable(list_rec_o) && $stable(list_num_o))
    else $error("listed record changed while stalled");
  a_list_order: assert property (list_valid_o && list_ready_i ##1 list_valid_o
    |-> list_num_o == $past(list_num_o) + 9'h001)
    else $error("record numbers not ascending");
  a_reset_state: assert property ($fell(rst_i) |-> log_freeze_o && !list_valid_o && !irq_o)
    else $error("wrong state after reset");

  c_listing: cover property (list_valid_o && list_ready_i);
  c_irq: cover property (irq_o);
  c_hold: cover property (pin_cmd_i.hold ##1 log_freeze_o);
endmodule : trl_monitor
`default_nettype wire

// ---- trl_list_sink.sv ----
// listing consumer model on the host side
`timescale 1ns/1ps
`default_nettype none
module trl_list_sink (
  // clock and clear
  input wire logic clk_i,
  input wire logic rst_i,
  // stream
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [8:0] num_i,
  output logic ready_o,
  // tally
  output logic [8:0] count_o,
  output logic [8:0] first_o,
  output logic [8:0] last_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b0;
      count_o <= 9'h000;
    end
    else
    begin
      // slow mode stalls every other cycle
      ready_o <= slow_i ? ~ready_o : 1'b1;
      if (valid_i && ready_o)
      begin
        if (count_o == 9'h000)
          first_o <= num_i;
        last_o <= num_i;
        count_o <= count_o + 9'h001;
      end
    end
  end
endmodule : trl_list_sink
`default_nettype wire

// ---- test_triggered_sample_logger.sv ----
// testbench of the triggered sample logger
`timescale 1ns/1ps
`default_nettype none
`include "trl_params.svh"
module test_triggered_sample_logger
  import trl_pkg::*;
();
  localparam int SMP = 4;
  logic clk = 1'b0, rst = 1'b1, srst = 1'b1, slow = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, lv, lready, frz, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q, saved;
  logic [8:0] lnum, scnt, sfirst, slast;
  trl_cmd_t key = '0, pin = '0;
  trl_rec_t lrec;
  logic [27:0] meas = 28'h0abcdef;
  int miscompares = 0, compares = 0, n;
  always #4 clk = ~clk;

  trl_logger #(.SAMPLE_MIN_CYC(SMP)) dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .meas_value_i(meas), .alarm_i(8'h5a), .tod_i(17'h1e240), .key_cmd_i(key),
    .pin_cmd_i(pin), .list_valid_o(lv), .list_rec_o(lrec), .list_num_o(lnum),
    .list_ready_i(lready), .log_freeze_o(frz), .irq_o(irq));
  trl_list_sink sink (.clk_i(clk), .rst_i(srst), .slow_i(slow), .valid_i(lv), .num_i(lnum),
    .ready_o(lready), .count_o(scnt), .first_o(sfirst), .last_o(slast));

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask : rdc
  task automatic pchk(input logic [7:0] k, input logic [8:0] e);
    wb(1'b1, `TRL_ADR_POINTER, {24'h0, k});
    rdc("number", `TRL_ADR_POINTER, 32'h01ff0000, {7'h0, e, 16'h0});
  endtask : pchk
  task automatic cmd(input logic k, input logic [3:0] c);
    if (k)
      key <= trl_cmd_t'(c);
    else
      pin <= trl_cmd_t'(c);
    @(posedge clk);
    key <= '0;
    pin <= '0;
    repeat (2) @(posedge clk);
  endtask : cmd
  task automatic wait_frz;
    n = 0;
    while (frz !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("freeze", 32'h1, {31'h0, frz});
    rdc("count", `TRL_ADR_STATUS, 32'h0001ff00, 32'h0001b400);
  endtask : wait_frz
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    srst <= 1'b0;
    @(posedge clk);
    rdc("interval", `TRL_ADR_INTERVAL, 32'h00ffffff, 32'h1);
    rdc("status", `TRL_ADR_STATUS, 32'h0001ff00, 32'h00010000);
    rdc("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    $display("test reset done");
    wb(1'b1, `TRL_ADR_CTRL, 32'h5);
    chk("running", 32'h0, {31'h0, frz});
    repeat (200 * SMP) @(posedge clk);
    // short spike that the min/max clearing must drop before the newest record
    meas <= 28'h0fffff0;
    @(posedge clk);
    meas <= 28'h0abcdef;
    repeat (3 * SMP) @(posedge clk);
    cmd(1'b0, 4'h8);
    rdc("count", `TRL_ADR_STATUS, 32'h0001ff00, 32'h0001b400);
    saved = q;
    repeat (10 * SMP) @(posedge clk);
    rdc("index", `TRL_ADR_STATUS, 32'h000000ff, saved & 32'hff);
    pchk(8'hb3, 9'h1ff);
    rdc("value", `TRL_ADR_VALUE, 32'h0fffffff, 32'h0abcdef);
    rdc("time", `TRL_ADR_TIME, 32'h0001ffff, 32'h1e240);
    rdc("min", `TRL_ADR_MIN, 32'h0fffffff, 32'h0abcdef);
    rdc("max", `TRL_ADR_MAX, 32'h0fffffff, 32'h0abcdef);
    pchk(8'h00, 9'h14c);
    wb(1'b1, `TRL_ADR_IRQ_MASK, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1'b1, `TRL_ADR_IRQ_MASK, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, `TRL_ADR_IRQ_STAT, 32'hf);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test continuous done");
    wb(1'b1, `TRL_ADR_CTRL, 32'h2);
    repeat (5 * SMP) @(posedge clk);
    cmd(1'b1, 4'h8);
    chk("freeze", 32'h1, {31'h0, frz});
    cmd(1'b1, 4'h4);
    chk("freeze", 32'h0, {31'h0, frz});
    repeat (30 * SMP) @(posedge clk);
    wb(1'b1, `TRL_ADR_CMD, 32'h4);
    wait_frz;
    pchk(8'h00, 9'h1ec);
    pchk(8'hb3, 9'h09f);
    $display("test pre trigger done");
    wb(1'b1, `TRL_ADR_CTRL, 32'h3);
    repeat (170 * SMP) @(posedge clk);
    cmd(1'b0, 4'h2);
    wait_frz;
    pchk(8'h00, 9'h160);
    pchk(8'hb3, 9'h013);
    $display("test post trigger done");
    slow <= 1'b1;
    cmd(1'b0, 4'h1);
    n = 0;
    while (scnt !== 9'hb4 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("listed", 32'hb4, {23'h0, scnt});
    chk("first", 32'h160, {23'h0, sfirst});
    chk("last", 32'h13, {23'h0, slast});
    chk("freeze", 32'h1, {31'h0, frz});
    $display("test listing done");
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule : test_triggered_sample_logger

bind trl_logger trl_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .key_cmd_i,
  .pin_cmd_i, .list_valid_o, .list_ready_i, .list_rec_o, .list_num_o, .log_freeze_o, .irq_o);
`default_nettype wire
